// File: hw/spi_master_slave_core.sv
`timescale 1ns/1ps
`default_nettype none
module spi_master_slave_core #(
  parameter int HALF_DIV = 4
) (
  input  wire logic             clock,
  input  wire logic             rst_b,
  input  wire logic             clk_en,
  input  wire logic             master_mode,
  input  wire logic             cpol,
  input  wire logic             cpha,
  input  wire logic             lsb_first,
  input  wire spi_pkg::cs_idx_t cs_sel,
  input  wire logic             irq_enable,
  input  wire logic             wake_enable,
  input  wire logic             standby_req,
  input  wire logic             wb_cyc_i,
  input  wire logic             wb_stb_i,
  input  wire logic             wb_we_i,
  input  wire spi_pkg::adr_t    wb_adr_i,
  input  wire spi_pkg::byte_t   wb_dat_i,
  output var  spi_pkg::byte_t   wb_dat_o,
  output var  logic             wb_ack_o,
  input  wire logic             spi_clk_i,
  output var  logic             spi_clk_o,
  output var  logic             spi_clk_oe,
  input  wire logic             spi_miso_i,
  output var  logic             spi_miso_o,
  output var  logic             spi_miso_oe,
  input  wire logic             spi_mosi_i,
  output var  logic             spi_mosi_o,
  output var  logic             spi_mosi_oe,
  output var  logic [7:0]       spi_csn,
  input  wire logic             spi_scsn,
  input  wire logic             config_logic_select_low,
  output var  logic             spi_irq,
  output var  logic             mode_fault,
  output var  logic             busy,
  output var  logic             cfg_stdby,
  output var  logic             cfg_wake
);
  import spi_pkg::*;

  localparam int DIV_W = (HALF_DIV > 1) ? $clog2(HALF_DIV) : 1;
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(HALF_DIV - 1);

  typedef enum logic [0:0] {M_IDLE, M_RUN} mstate_t;

  function automatic logic [NUM_CS-1:0] cs_onehot(input cs_idx_t idx, input logic act);
    logic [NUM_CS-1:0] v;
    v = '0;
    for (int i = 0; i < NUM_CS; i++) begin
      v[i] = act && (cs_idx_t'(i) == idx);
    end
    return v;
  endfunction

  shift_if sif ();

  logic [SY_W-1:0]   sync1_r;
  logic [SY_W-1:0]   sync2_r;
  logic              sclk_prev_r;
  logic              sel_prev_r;
  mstate_t           state_r;
  logic [DIV_W-1:0]  div_r;
  logic [3:0]        edge_r;
  logic              sclk_r;
  logic              more_r;
  byte_t             tx_buf_r;
  logic              tx_full_r;
  byte_t             rx_buf_r;
  logic              rx_full_r;
  logic              modf_r;
  logic              overrun_r;
  logic              ack_r;
  byte_t             rdata_r;
  logic [NUM_CS-1:0] csn_r;
  logic              wake_r;
  logic              stdby_r;

  logic wb_req;
  logic wr_data;
  logic rd_data;
  logic wr_status;
  logic sclk_s;
  logic sel_s;
  logic toggle;
  logic lead;
  logic trail;
  logic start_m;
  logic start_s;
  logic take_tx;
  logic end_m;
  logic fault_ev;

  // Each pin input passes two flops; only the second stage is read.
  genvar g;
  generate
    for (g = 0; g < SY_W; g++) begin : g_sync
      always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
          sync1_r[g] <= 1'b1;
          sync2_r[g] <= 1'b1;
        end else if (clk_en) begin
          sync1_r[g] <= (g == SY_CLK)  ? spi_clk_i :
                        (g == SY_MOSI) ? spi_mosi_i :
                        (g == SY_MISO) ? spi_miso_i :
                        (g == SY_SCSN) ? spi_scsn : config_logic_select_low;
          sync2_r[g] <= sync1_r[g];
        end
      end
    end
  endgenerate

  assign sclk_s = sync2_r[SY_CLK];
  // The core is reached only while the external master holds its select low and leaves the
  // configuration select high, so configuration traffic never disturbs the shifter.
  assign sel_s  = !master_mode && !sync2_r[SY_SCSN] && sync2_r[SY_CFG];

  // Another master pulling our select low while we are master is a bus conflict.
  assign fault_ev = master_mode && !sync2_r[SY_SCSN];

  assign toggle = (state_r == M_RUN) && (div_r == DIV_LAST);
  // Slave edges count only while selected.
  assign lead  = master_mode ? (toggle && (sclk_r == cpol))
                             : (sel_s && (sclk_prev_r == cpol) && (sclk_s != cpol));
  assign trail = master_mode ? (toggle && (sclk_r != cpol))
                             : (sel_s && (sclk_prev_r != cpol) && (sclk_s == cpol));

  assign start_m = master_mode && (state_r == M_IDLE) && tx_full_r && !modf_r && !fault_ev;
  assign start_s = sel_s && !sel_prev_r;
  // A load that picks up the waiting byte empties the holder unless a write refills it in the same cycle, so no byte is ever sent twice.
  assign take_tx = tx_full_r && sif.load;
  assign end_m   = toggle && (edge_r == LAST_EDGE);

  assign sif.load       = start_m || start_s || (sif.done && (master_mode ? tx_full_r : sel_s));
  assign sif.load_data  = tx_full_r ? tx_buf_r : IDLE_FILL;
  assign sif.lsb_first  = lsb_first;
  // A reload at the end of a byte comes before the byte's last launch edge in the first phase,
  // so that edge must not shift the fresh byte; in the second phase the first bit is already out.
  assign sif.skip_first = cpha || sif.done;
  // Phase picks which edge samples and which edge launches.
  assign sif.sample     = cpha ? trail : lead;
  assign sif.shift      = cpha ? lead : trail;
  assign sif.in_bit     = master_mode ? sync2_r[SY_MISO] : sync2_r[SY_MOSI];

  spi_shifter u_shifter (
    .clock  (clock),
    .rst_b  (rst_b),
    .clk_en (clk_en),
    .port   (sif.sh)
  );

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      sclk_prev_r <= 1'b0;
      sel_prev_r  <= 1'b0;
    end else if (clk_en) begin
      sclk_prev_r <= sclk_s;
      sel_prev_r  <= sel_s;
    end
  end

  // Master sequencer: sixteen clock edges per byte, back to back while bytes wait.
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      state_r <= M_IDLE;
      div_r   <= '0;
      edge_r  <= 4'h0;
      sclk_r  <= 1'b0;
      more_r  <= 1'b0;
    end else if (clk_en) begin
      case (state_r)
        M_IDLE: begin
          sclk_r <= cpol;
          div_r  <= '0;
          edge_r <= 4'h0;
          if (start_m) begin
            state_r <= M_RUN;
            more_r  <= 1'b0;
          end
        end
        M_RUN: begin
          if (fault_ev || !master_mode) begin
            state_r <= M_IDLE;
          end else begin
            div_r <= toggle ? '0 : div_r + DIV_W'(1);
            if (toggle) begin
              sclk_r <= !sclk_r;
              edge_r <= edge_r + 4'h1;
            end
            if (sif.done) begin
              more_r <= tx_full_r;
            end
            if (end_m) begin
              more_r <= 1'b0;
              if (!more_r && !(sif.done && tx_full_r)) begin
                state_r <= M_IDLE;
              end
            end
          end
        end
        default: state_r <= M_IDLE;
      endcase
    end
  end

  assign wb_req    = wb_cyc_i && wb_stb_i && !ack_r;
  assign wr_data   = wb_req && wb_we_i && (wb_adr_i == ADR_DATA);
  assign rd_data   = wb_req && !wb_we_i && (wb_adr_i == ADR_DATA);
  assign wr_status = wb_req && wb_we_i && (wb_adr_i == ADR_STATUS);

  // A write into a full transmit holder replaces the waiting byte.
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      tx_buf_r  <= ZERO_BYTE;
      tx_full_r <= 1'b0;
    end else if (clk_en) begin
      if (wr_data) begin
        tx_buf_r  <= wb_dat_i;
        tx_full_r <= 1'b1;
      end else if (take_tx) begin
        tx_full_r <= 1'b0;
      end
    end
  end

  // A finished byte sets the full flag even when a read clears it in the same cycle.
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      rx_buf_r  <= ZERO_BYTE;
      rx_full_r <= 1'b0;
      overrun_r <= 1'b0;
    end else if (clk_en) begin
      if (sif.done) begin
        rx_buf_r  <= sif.rx_data;
        rx_full_r <= 1'b1;
      end else if (rd_data) begin
        rx_full_r <= 1'b0;
      end
      if (sif.done && rx_full_r && !rd_data) begin
        overrun_r <= 1'b1;
      end else if (wr_status && wb_dat_i[ST_OVERRUN]) begin
        overrun_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      modf_r <= 1'b0;
    end else if (clk_en) begin
      if (fault_ev) begin
        modf_r <= 1'b1;
      end else if (wr_status && wb_dat_i[ST_MODF]) begin
        modf_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      ack_r   <= 1'b0;
      rdata_r <= ZERO_BYTE;
    end else if (clk_en) begin
      ack_r   <= wb_req;
      rdata_r <= ZERO_BYTE;
      if (wb_req && !wb_we_i) begin
        if (wb_adr_i == ADR_DATA) begin
          rdata_r <= rx_buf_r;
        end else if (wb_adr_i == ADR_STATUS) begin
          rdata_r[ST_TX_FULL] <= tx_full_r;
          rdata_r[ST_RX_FULL] <= rx_full_r;
          rdata_r[ST_MODF]    <= modf_r;
          rdata_r[ST_OVERRUN] <= overrun_r;
          rdata_r[ST_BUSY]    <= (state_r == M_RUN) || sel_s;
        end
      end
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      csn_r   <= '1;
      wake_r  <= 1'b0;
      stdby_r <= 1'b0;
    end else if (clk_en) begin
      csn_r   <= ~cs_onehot(cs_sel, master_mode && (state_r == M_RUN || start_m));
      wake_r  <= wake_enable && sel_s;
      stdby_r <= wake_enable && standby_req;
    end
  end

  assign wb_dat_o    = rdata_r;
  assign wb_ack_o    = ack_r;
  assign spi_clk_o   = sclk_r;
  assign spi_clk_oe  = master_mode;
  assign spi_mosi_o  = sif.out_bit;
  assign spi_mosi_oe = master_mode;
  assign spi_miso_o  = sif.out_bit;
  assign spi_miso_oe = sel_s;
  assign spi_csn     = csn_r;
  assign spi_irq     = modf_r && irq_enable;
  assign mode_fault  = modf_r;
  assign busy        = (state_r == M_RUN) || sel_s;
  assign cfg_wake    = wake_r;
  assign cfg_stdby   = stdby_r;
endmodule
`default_nettype wire

// File: hw/spi_shifter.sv
`timescale 1ns/1ps
`default_nettype none
module spi_shifter (
  input  wire logic clock,
  input  wire logic rst_b,
  input  wire logic clk_en,
  shift_if.sh       port
);
  import spi_pkg::*;

  byte_t      sreg_r;
  byte_t      rx_r;
  logic [3:0] cnt_r;
  logic       skip_r;
  logic       done_r;

  // With the second phase the first bit is already on the line at load, so the first launch edge must not shift.
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      sreg_r <= IDLE_FILL;
      skip_r <= 1'b0;
    end else if (clk_en) begin
      if (port.load) begin
        sreg_r <= port.load_data;
        skip_r <= port.skip_first;
      end else if (port.shift) begin
        if (skip_r) begin
          skip_r <= 1'b0;
        end else if (port.lsb_first) begin
          sreg_r <= {1'b1, sreg_r[BYTE_W-1:1]};
        end else begin
          sreg_r <= {sreg_r[BYTE_W-2:0], 1'b1};
        end
      end
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      rx_r   <= ZERO_BYTE;
      cnt_r  <= 4'h0;
      done_r <= 1'b0;
    end else if (clk_en) begin
      done_r <= 1'b0;
      if (port.load) begin
        cnt_r <= 4'h0;
      end else if (port.sample) begin
        // Received bits land in the same order that they are sent.
        rx_r   <= port.lsb_first ? {port.in_bit, rx_r[BYTE_W-1:1]} : {rx_r[BYTE_W-2:0], port.in_bit};
        cnt_r  <= (cnt_r == LAST_BIT) ? 4'h0 : cnt_r + 4'h1;
        done_r <= (cnt_r == LAST_BIT);
      end
    end
  end

  assign port.out_bit = port.lsb_first ? sreg_r[0] : sreg_r[BYTE_W-1];
  assign port.done    = done_r;
  assign port.rx_data = rx_r;
endmodule
`default_nettype wire

// File: inc/shift_if.sv
`timescale 1ns/1ps
`default_nettype none
interface shift_if;
  logic            load;
  spi_pkg::byte_t  load_data;
  logic            lsb_first;
  logic            skip_first;
  logic            sample;
  logic            shift;
  logic            in_bit;
  logic            out_bit;
  logic            done;
  spi_pkg::byte_t  rx_data;
  modport ctl (output load, load_data, lsb_first, skip_first, sample, shift, in_bit,
               input out_bit, done, rx_data);
  modport sh  (input load, load_data, lsb_first, skip_first, sample, shift, in_bit,
               output out_bit, done, rx_data);
endinterface
`default_nettype wire

// File: inc/spi_pkg.sv
package spi_pkg;
  localparam int BYTE_W = 8;
  localparam int NUM_CS = 8;
  localparam int CS_W   = 3;
  localparam int ADR_W  = 2;
  typedef logic [BYTE_W-1:0] byte_t;
  typedef logic [CS_W-1:0]   cs_idx_t;
  typedef logic [ADR_W-1:0]  adr_t;
  localparam adr_t ADR_DATA   = 2'h0;
  localparam adr_t ADR_STATUS = 2'h1;
  localparam int ST_TX_FULL = 0;
  localparam int ST_RX_FULL = 1;
  localparam int ST_MODF    = 2;
  localparam int ST_OVERRUN = 3;
  localparam int ST_BUSY    = 4;
  localparam byte_t IDLE_FILL = 8'hff;
  localparam byte_t ZERO_BYTE = 8'h00;
  localparam int SY_CLK  = 0;
  localparam int SY_MOSI = 1;
  localparam int SY_MISO = 2;
  localparam int SY_SCSN = 3;
  localparam int SY_CFG  = 4;
  localparam int SY_W    = 5;
  localparam logic [3:0] LAST_EDGE = 4'hf;
  localparam logic [3:0] LAST_BIT  = 4'h7;
endpackage

// File: verif/spi_core_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module spi_core_assertions #(
  parameter int HALF_DIV = 4
) (
  input wire logic       clock,
  input wire logic       rst_b,
  input wire logic       clk_en,
  input wire logic       master_mode,
  input wire logic       cpol,
  input wire logic       irq_enable,
  input wire logic       wake_enable,
  input wire logic       wb_cyc_i,
  input wire logic       wb_stb_i,
  input wire logic       wb_ack_o,
  input wire logic       spi_clk_o,
  input wire logic       spi_clk_oe,
  input wire logic       spi_miso_oe,
  input wire logic       spi_mosi_oe,
  input wire logic [7:0] spi_csn,
  input wire logic       spi_scsn,
  input wire logic       spi_irq,
  input wire logic       mode_fault,
  input wire logic       cfg_stdby,
  input wire logic       cfg_wake
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_b);
  // A request counts only while no answer stands, so a held strobe is not taken twice.
  sequence s_req; wb_cyc_i && wb_stb_i && !wb_ack_o && clk_en; endsequence
  sequence s_idle; master_mode && &spi_csn; endsequence
  property p_ack; s_req |=> wb_ack_o ##1 !wb_ack_o; endproperty
  a_ack: assert property (p_ack) else $error("ack late or too long");
  property p_clk_dir; spi_clk_oe == master_mode; endproperty
  a_clk_dir: assert property (p_clk_dir) else $error("clock direction wrong");
  property p_mosi_dir; spi_mosi_oe == master_mode; endproperty
  a_mosi_dir: assert property (p_mosi_dir) else $error("mosi direction wrong");
  property p_miso_dir; spi_miso_oe |-> !master_mode; endproperty
  a_miso_dir: assert property (p_miso_dir) else $error("miso driven as master");
  property p_release; spi_scsn [*4] |-> !spi_miso_oe; endproperty
  a_release: assert property (p_release) else $error("miso driven while deselected");
  property p_one_cs; $countones(~spi_csn) <= 1; endproperty
  a_one_cs: assert property (p_one_cs) else $error("several selects low");
  property p_fault; (master_mode && !spi_scsn) [*5] |-> mode_fault; endproperty
  a_fault: assert property (p_fault) else $error("mode fault not flagged");
  property p_irq; spi_irq == (mode_fault && irq_enable); endproperty
  a_irq: assert property (p_irq) else $error("irq does not follow fault");
  property p_idle_clk; s_idle ##1 (s_idle and $stable(cpol)) |-> spi_clk_o == cpol; endproperty
  a_idle_clk: assert property (p_idle_clk) else $error("idle clock level wrong");
  property p_wake_off; !wake_enable [*2] |-> !cfg_stdby && !cfg_wake; endproperty
  a_wake_off: assert property (p_wake_off) else $error("power outputs active");
endmodule
bind spi_master_slave_core spi_core_assertions #(.HALF_DIV(HALF_DIV)) i_chk (.clock, .rst_b, .clk_en,
  .master_mode, .cpol, .irq_enable, .wake_enable, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .spi_clk_o, .spi_clk_oe,
  .spi_miso_oe, .spi_mosi_oe, .spi_csn, .spi_scsn, .spi_irq, .mode_fault, .cfg_stdby, .cfg_wake);
`default_nettype wire

// File: verif/spi_dev_model.sv
`timescale 1ns/1ps
`default_nettype none
module spi_dev_model (
  input  wire logic       sclk,
  input  wire logic       csn,
  input  wire logic       mosi,
  input  wire logic       cpol,
  input  wire logic       cpha,
  input  wire logic       lsb,
  input  wire logic [7:0] tx,
  output var  logic       miso,
  output var  logic [7:0] rx
);
  int ni = 0;
  int no = 0;
  logic [7:0] sh = 8'h00;
  initial miso = 1'b0;
  initial rx = 8'h00;
  function automatic int ix(input int k);
    return lsb ? k : 7 - k;
  endfunction
  task automatic put();
    miso = tx[ix(no)];
    no++;
  endtask
  always @(negedge csn) begin
    ni = 0;
    no = 0;
    if (!cpha) put();
  end
  // A released line must not keep its last bit, or a stale value could pass for data.
  always @(posedge csn) miso = ~miso;
  always @(sclk) if (!csn) begin
    if ((sclk != cpol) != cpha) begin
      sh[ix(ni)] = mosi;
      ni++;
      if (ni == 8) begin
        rx = sh;
        ni = 0;
        no = 0;
      end
    end else put();
  end
endmodule
`default_nettype wire

// File: verif/spi_master_slave_core_bench.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, x) begin checks_done++; if ((g) !== (x)) begin n_mismatch++; $display("Error t=%0t got %h exp %h", $time, g, x); end end
module spi_master_slave_core_bench;
  import spi_pkg::*;
  logic clock = 0, rst_b = 0, master_mode = 1, cpol = 0, cpha = 0, lsb_first = 0, irq_enable = 0;
  logic wake_enable = 0, standby_req = 0, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0, spi_scsn = 1, clk_en = 1;
  logic config_logic_select_low = 1, b_sclk = 0, b_mosi = 0, dev_miso, wb_ack_o, spi_clk_o, spi_clk_oe;
  logic spi_miso_o, spi_miso_oe, spi_mosi_o, spi_mosi_oe, spi_irq, mode_fault, busy, cfg_stdby, cfg_wake;
  logic [7:0] spi_csn;
  cs_idx_t cs_sel = 3'h0;
  adr_t wb_adr_i = 2'h0;
  byte_t wb_dat_i = 8'h00, wb_dat_o, dev_tx = 8'h00, dev_rx, rnd = 8'h33, b, r, e;
  int n_mismatch = 0, checks_done = 0;
  byte_t expq[$];
  // Each shared pin takes the level of whichever side has its enable up.
  wire logic sclk = spi_clk_oe ? spi_clk_o : b_sclk;
  wire logic mosi = spi_mosi_oe ? spi_mosi_o : b_mosi;
  wire logic miso = spi_miso_oe ? spi_miso_o : dev_miso;
  spi_master_slave_core #(.HALF_DIV(4)) i_dut (.clock, .rst_b, .clk_en, .master_mode, .cpol, .cpha,
    .lsb_first, .cs_sel, .irq_enable, .wake_enable, .standby_req, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
    .wb_dat_i, .wb_dat_o, .wb_ack_o, .spi_clk_i(sclk), .spi_clk_o, .spi_clk_oe, .spi_miso_i(miso), .spi_miso_o,
    .spi_miso_oe, .spi_mosi_i(mosi), .spi_mosi_o, .spi_mosi_oe, .spi_csn, .spi_scsn, .config_logic_select_low,
    .spi_irq, .mode_fault, .busy, .cfg_stdby, .cfg_wake);
  spi_dev_model i_dev (.sclk, .csn(spi_csn[cs_sel]), .mosi, .cpol, .cpha, .lsb(lsb_first), .tx(dev_tx),
    .miso(dev_miso), .rx(dev_rx));
  always #4 clock = ~clock;
  function automatic byte_t nx(input byte_t s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  task conclude;
    $display("mismatches %0d checks %0d", n_mismatch, checks_done);
    if (n_mismatch == 0 && checks_done > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task wb(input adr_t a, input logic w, input byte_t d);
    int n;
    n = 0;
    @(negedge clock);
    {wb_adr_i, wb_we_i, wb_dat_i, wb_cyc_i, wb_stb_i} = {a, w, d, 2'b11};
    do @(posedge clock); while (!wb_ack_o && ++n < 9);
    if (n == 9) n_mismatch++;
    @(negedge clock);
    {wb_cyc_i, wb_stb_i} = 2'b00;
  endtask
  task rd(input adr_t a, input byte_t x);
    expq.push_back(x);
    wb(a, 1'b0, 8'h00);
  endtask
  task wait_idle();
    int n;
    n = 0;
    repeat (3) @(negedge clock);
    while ((busy || spi_csn !== 8'hff) && n++ < 400) @(negedge clock);
    `CHK(busy, 1'b0)
  endtask
  // The far master's clock moves only inside the frame and has no phase tie to the core clock.
  task ext(input byte_t o, output byte_t i);
    spi_scsn = 0;
    #125;
    `CHK({cfg_wake, spi_miso_oe}, {wake_enable, 1'b1})
    for (int k = 0; k < 8; k++) begin
      if (cpha) b_sclk = ~b_sclk;
      b_mosi = o[lsb_first ? k : 7 - k];
      #62.5;
      b_sclk = ~b_sclk;
      i[lsb_first ? k : 7 - k] = miso;
      #62.5;
      if (!cpha) b_sclk = ~b_sclk;
    end
    #62.5;
    spi_scsn = 1;
    b_mosi = ~b_mosi;
    #125;
  endtask
  always @(posedge clock) if (wb_ack_o && !wb_we_i) begin
    e = expq.pop_front();
    `CHK(wb_dat_o, e)
  end
  initial begin
    repeat (2) @(negedge clock);
    rst_b = 1;
    `CHK(spi_csn, 8'hff)
    rd(ADR_STATUS, ZERO_BYTE);
    wb(2'h3, 1'b1, 8'h5a);
    rd(2'h3, ZERO_BYTE);
    for (int m = 0; m < 8; m++) begin
      {lsb_first, cpol, cpha} = m[2:0];
      cs_sel = rnd[2:0];
      dev_tx = nx(rnd);
      b = rnd ^ 8'h5a;
      wb(ADR_DATA, 1'b1, b);
      wb(ADR_DATA, 1'b1, ~b);
      wait_idle();
      `CHK(dev_rx, ~b)
      rd(ADR_STATUS, 8'h0a);
      rd(ADR_DATA, dev_tx);
      wb(ADR_STATUS, 1'b1, 8'h08);
      rd(ADR_STATUS, ZERO_BYTE);
      rnd = nx(dev_tx);
    end
    irq_enable = 1;
    spi_scsn = 0;
    repeat (6) @(negedge clock);
    `CHK({mode_fault, spi_irq}, 2'b11)
    wb(ADR_DATA, 1'b1, 8'h3c);
    irq_enable = 0;
    @(negedge clock);
    `CHK({spi_csn, spi_irq}, 9'h1fe)
    rd(ADR_STATUS, 8'h05);
    spi_scsn = 1;
    repeat (4) @(negedge clock);
    master_mode = 0;
    wb(ADR_STATUS, 1'b1, 8'h04);
    rd(ADR_STATUS, 8'h01);
    b = 8'h3c;
    for (int m = 0; m < 4; m++) begin
      @(negedge clock);
      {cpol, cpha} = m[1:0];
      lsb_first = m[0] ^ m[1];
      wake_enable = m[0];
      b_sclk = m[1];
      if (m > 0) begin
        b = rnd;
        wb(ADR_DATA, 1'b1, b);
      end
      ext(~rnd, r);
      `CHK(r, b)
      rd(ADR_DATA, ~rnd);
      rnd = nx(rnd);
    end
    config_logic_select_low = 0;
    spi_scsn = 0;
    #200;
    `CHK({spi_miso_oe, busy}, 2'b00)
    spi_scsn = 1;
    config_logic_select_low = 1;
    @(negedge clock);
    // With the enable low the power outputs must hold their old level.
    clk_en = 0;
    {wake_enable, standby_req} = 2'b11;
    repeat (2) @(negedge clock);
    `CHK(cfg_stdby, 1'b0)
    clk_en = 1;
    repeat (2) @(negedge clock);
    `CHK(cfg_stdby, 1'b1)
    wake_enable = 0;
    repeat (2) @(negedge clock);
    `CHK({cfg_stdby, cfg_wake}, 2'b00)
    conclude;
  end
  initial begin
    #200000;
    n_mismatch++;
    conclude;
  end
endmodule
`default_nettype wire
